// [touch_timing_pkg.sv]
// Constants, decode functions and types for touch timing configuration
package touch_timing_pkg;

	// ------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 125;     // Core clock, MHz
	localparam int MS_US        = 1000;    // One millisecond, us
	localparam int SAMP_UNIT_US = 320;     // Shortest sample time, us
	localparam int MS_CYC_DEF   = CLK_MHZ * MS_US;
	localparam int SAMP_CYC_DEF = CLK_MHZ * SAMP_UNIT_US;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DUR_RPT  = 8'h22;
	localparam logic [7:0] ADDR_HOLD     = 8'h23;
	localparam logic [7:0] ADDR_AVG      = 8'h24;
	localparam logic [7:0] RST_DUR_RPT   = 8'hA4;
	localparam logic [7:0] RST_HOLD      = 8'h07;
	localparam logic [7:0] RST_AVG       = 8'h39;
	localparam logic [7:0] MASK_DUR_RPT  = 8'hFF;
	localparam logic [7:0] MASK_HOLD     = 8'h0F;
	localparam logic [7:0] MASK_AVG      = 8'h7F;
	localparam logic [7:0] RDATA_NONE    = 8'h00;
	localparam int DUR_MSB = 7, DUR_LSB = 4, RPT_MSB = 3, RPT_LSB = 0;
	localparam int HLD_MSB = 3, HLD_LSB = 0, AVG_MSB = 6, AVG_LSB = 4;
	localparam int SMP_MSB = 3, SMP_LSB = 2, CYC_MSB = 1, CYC_LSB = 0;

	// ------------------------------------------------------------
	// Widths and types
	// ------------------------------------------------------------
	localparam int NCH    = 3;
	localparam int DATA_W = 8;
	localparam int ACC_W  = 15;
	typedef logic [13:0] ms_t;
	localparam ms_t      STEP_MS  = 14'h0023;  // 35 ms step
	localparam logic [3:0] SMP_ONE = 4'h1;
	localparam logic [7:0] AVG_ONE = 8'h01;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_WAIT   = 2'b10
	} seq_state_e;

	// Touch timeout code to milliseconds
	function automatic ms_t dur_ms(input logic [3:0] c);
		case (c)
			4'h0: dur_ms = 14'h0230;   // 560
			4'h1: dur_ms = 14'h0348;   // 840
			4'h2: dur_ms = 14'h0460;   // 1120
			4'h3: dur_ms = 14'h0578;   // 1400
			4'h4: dur_ms = 14'h0690;   // 1680
			4'h5: dur_ms = 14'h08C0;   // 2240
			4'h6: dur_ms = 14'h0AF0;   // 2800
			4'h7: dur_ms = 14'h0D20;   // 3360
			4'h8: dur_ms = 14'h0F50;   // 3920
			4'h9: dur_ms = 14'h1180;   // 4480
			4'hA: dur_ms = 14'h15E0;   // 5600
			4'hB: dur_ms = 14'h1A40;   // 6720
			4'hC: dur_ms = 14'h1EA0;   // 7840
			4'hD: dur_ms = 14'h22CA;   // 8906
			4'hE: dur_ms = 14'h2760;   // 10080
			default: dur_ms = 14'h2BC0; // 11200
		endcase
	endfunction

	// (code + 1) steps of 35 ms
	function automatic ms_t step_ms(input logic [3:0] c);
		step_ms = ms_t'((ms_t'(c) + 14'h0001) * STEP_MS);
	endfunction

endpackage

// [touch_timer_if.sv]
// Signals between the sequencer and the per-input touch timers
interface touch_timer_if;
	import touch_timing_pkg::*;
	logic           tick_ms;
	logic [NCH-1:0] touch;
	logic           recal_en;
	logic [NCH-1:0] rpt_en;
	ms_t            dur;
	ms_t            hold;
	ms_t            rpt;
	logic           int_req   [NCH];
	logic           recal_req [NCH];
	logic           hold_evt  [NCH];

	modport core (output tick_ms, touch, recal_en, rpt_en, dur, hold, rpt,
		input int_req, recal_req, hold_evt);
	modport chan (input tick_ms, touch, recal_en, rpt_en, dur, hold, rpt,
		output int_req, recal_req, hold_evt);
endinterface

// [tick_divider.sv]
// Restartable divider giving one-cycle ticks
module tick_divider
	import touch_timing_pkg::*;
#(
	parameter int unsigned PERIOD = 2
)(
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	input  wire logic i_restart,
	output logic      o_tick
);
	localparam int W = $clog2(PERIOD);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);

	logic [W-1:0] cnt_r, cnt_nxt;
	logic         tick_nxt;

	// Count and wrap
	always_comb begin
		cnt_nxt  = cnt_r + W'(1);
		tick_nxt = 1'h0;
		if (i_restart) begin
			cnt_nxt = '0;
		end else if (cnt_r == LAST) begin
			cnt_nxt  = '0;
			tick_nxt = 1'h1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_r  <= '0;
			o_tick <= 1'h0;
		end else begin
			cnt_r  <= cnt_nxt;
			o_tick <= tick_nxt;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	property p_tick_gap;
		o_tick |=> !o_tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("tick repeated on adjacent cycles");

endmodule // tick_divider

// [touch_hold_timer.sv]
// Per-input touch duration, hold qualification and repeat timer
module touch_hold_timer
	import touch_timing_pkg::*;
#(
	parameter int CH = 0
)(
	input  wire logic   i_core_clk,
	input  wire logic   i_rstn,
	touch_timer_if.chan tif
);
	logic touch, rise;
	ms_t  held_r, held_nxt, rpt_r, rpt_nxt;
	logic tch_d_r, done_r, done_nxt, hold_r, hold_nxt;
	logic int_r, int_nxt, recal_r, recal_nxt;

	assign touch = tif.touch[CH];
	assign rise  = touch && !tch_d_r;

	// Duration and repeat counting
	always_comb begin
		held_nxt  = held_r;
		rpt_nxt   = rpt_r;
		done_nxt  = done_r;
		int_nxt   = 1'h0;
		recal_nxt = 1'h0;
		hold_nxt  = touch && tif.rpt_en[CH] && (held_r > tif.hold);
		if (!touch) begin
			held_nxt = '0;
			rpt_nxt  = '0;
			done_nxt = 1'h0;
		end else if (rise) begin
			held_nxt = '0;
			int_nxt  = 1'h1;
		end else if (tif.tick_ms) begin
			if (held_r != '1) begin
				held_nxt = held_r + 14'h0001;
			end
			rpt_nxt = hold_r ? rpt_r + 14'h0001 : '0;
		end
		if (hold_r && rpt_r >= tif.rpt && touch) begin
			int_nxt = 1'h1;
			rpt_nxt = '0;
		end
		if (tif.recal_en && touch && !done_r && held_r > tif.dur) begin
			recal_nxt = 1'h1;
			done_nxt  = 1'h1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			held_r  <= '0;
			rpt_r   <= '0;
			tch_d_r <= 1'h0;
			done_r  <= 1'h0;
			hold_r  <= 1'h0;
			int_r   <= 1'h0;
			recal_r <= 1'h0;
		end else begin
			held_r  <= held_nxt;
			rpt_r   <= rpt_nxt;
			tch_d_r <= touch;
			done_r  <= done_nxt;
			hold_r  <= hold_nxt;
			int_r   <= int_nxt;
			recal_r <= recal_nxt;
		end
	end

	assign tif.int_req[CH]   = int_r;
	assign tif.recal_req[CH] = recal_r;
	assign tif.hold_evt[CH]  = hold_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	property p_recal_cause;
		recal_r |-> $past(touch && tif.recal_en && held_r > tif.dur);
	endproperty
	a_recal_cause: assert property (p_recal_cause)
		else $error("recalibration without timed-out touch");

	property p_hold_qual;
		$rose(hold_r) |-> $past(held_r > tif.hold && tif.rpt_en[CH]);
	endproperty
	a_hold_qual: assert property (p_hold_qual)
		else $error("hold event before qualify time");

endmodule // touch_hold_timer

// [touch_sense_timing_config.sv]
// Touch sensing timing registers, cycle sequencer and touch timers
// Operation
// - Touch timeout code in bits 7:4 of first register, reset 1010b.
// - Timeout codes decode to 560 ms up to 11200 ms.
// - Enabled timeout recalibrates an input touched too long.
// - Repeat code in bits 3:0, reset 0100b, (code+1) x 35 ms.
// - Held auto-repeat input interrupts on touch, then at interval.
// - Hold code in second register bits 3:0, reset 0111b.
// - Repeat-enabled touch longer than hold time is press-and-hold, else plain.
// - Averaging code bits 6:4 selects 2^n samples, reset 8.
// - Samples per channel back to back, channels in order.
// - Sample time code bits 3:2: 320us to 2.56ms, reset 2.
// - Cycle code bits 1:0: 35 to 140 ms, reset 70.
// - Sample all enabled channels first, then low-power wait.
// - Cycle stretches when samples need more than cycle time.
// - Settings apply to all enabled inputs in active state.
// - Timeout and repeat settings shared by all three inputs.
// - Only enabled channels sampled; cycle length independent of them unless stretched.
module touch_sense_timing_config
	import touch_timing_pkg::*;
#(
	parameter int unsigned MS_CYC   = MS_CYC_DEF,
	parameter int unsigned SAMP_CYC = SAMP_CYC_DEF
)(
	input  wire logic              i_core_clk,
	input  wire logic              i_rstn,
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic              i_reg_wr,
	input  wire logic [7:0]        i_reg_wdata,
	output logic      [7:0]        o_reg_rdata,
	input  wire logic              i_active_mode,
	input  wire logic              i_recal_enable,
	input  wire logic [NCH-1:0]    i_chan_enable,
	input  wire logic [NCH-1:0]    i_repeat_enable,
	input  wire logic [NCH-1:0]    i_touch,
	input  wire logic [DATA_W-1:0] i_sample_data,
	output logic                   o_sample_busy,
	output logic      [1:0]        o_sample_chan,
	output logic                   o_sample_strobe,
	output logic                   o_low_power,
	output logic                   o_meas_valid,
	output logic      [1:0]        o_meas_chan,
	output logic      [DATA_W-1:0] o_meas_result,
	output logic      [NCH-1:0]    o_int_req,
	output logic      [NCH-1:0]    o_recal_req,
	output logic      [NCH-1:0]    o_hold_event
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0]        reg_dur_r, reg_dur_nxt;
	logic [7:0]        reg_hold_r, reg_hold_nxt;
	logic [7:0]        reg_avg_r, reg_avg_nxt;
	logic [7:0]        rdata_nxt;
	seq_state_e        st_r, st_nxt;
	logic [1:0]        ch_r, ch_nxt;
	logic [3:0]        units_r, units_nxt;
	logic [7:0]        idx_r, idx_nxt;
	logic [ACC_W-1:0]  acc_r, acc_nxt, acc_sum;
	ms_t               cyc_ms_r, cyc_ms_nxt;
	logic [7:0]        sh_dur_r, sh_dur_nxt;
	logic [7:0]        sh_hold_r, sh_hold_nxt;
	logic [7:0]        sh_avg_r, sh_avg_nxt;
	logic [NCH-1:0]    sh_en_r, sh_en_nxt;
	logic              busy_nxt, lp_nxt, strobe_nxt;
	logic              mval_nxt;
	logic [1:0]        mchan_nxt;
	logic [DATA_W-1:0] mres_nxt;
	logic              cyc_tick, smp_tick;
	logic              cyc_done, cyc_start, smp_last, meas_last;
	logic [2:0]        first_pick, next_pick;
	logic [3:0]        smp_units;
	logic [7:0]        avg_cnt;
	logic [2:0]        avg_code;

	touch_timer_if tif ();

	// First enabled channel at or above lo, valid flag on top
	function automatic logic [2:0] pick_ch(input logic [NCH-1:0] en,
		input logic [1:0] lo);
		logic found;
		found   = 1'h0;
		pick_ch = 3'h0;
		for (int i = 0; i < NCH; i++) begin
			if (!found && en[i] && 2'(i) >= lo) begin
				found   = 1'h1;
				pick_ch = {1'h1, 2'(i)};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	// Write decode and read mux
	always_comb begin
		reg_dur_nxt  = reg_dur_r;
		reg_hold_nxt = reg_hold_r;
		reg_avg_nxt  = reg_avg_r;
		if (i_reg_wr) begin
			if (i_reg_addr == ADDR_DUR_RPT) begin
				reg_dur_nxt = i_reg_wdata & MASK_DUR_RPT;
			end else if (i_reg_addr == ADDR_HOLD) begin
				reg_hold_nxt = i_reg_wdata & MASK_HOLD;
			end else if (i_reg_addr == ADDR_AVG) begin
				reg_avg_nxt = i_reg_wdata & MASK_AVG;
			end
		end
		if (i_reg_addr == ADDR_DUR_RPT) begin
			rdata_nxt = reg_dur_r;
		end else if (i_reg_addr == ADDR_HOLD) begin
			rdata_nxt = reg_hold_r;
		end else if (i_reg_addr == ADDR_AVG) begin
			rdata_nxt = reg_avg_r;
		end else begin
			rdata_nxt = RDATA_NONE;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			reg_dur_r   <= RST_DUR_RPT;
			reg_hold_r  <= RST_HOLD;
			reg_avg_r   <= RST_AVG;
			o_reg_rdata <= RDATA_NONE;
		end else begin
			reg_dur_r   <= reg_dur_nxt;
			reg_hold_r  <= reg_hold_nxt;
			reg_avg_r   <= reg_avg_nxt;
			o_reg_rdata <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Timebases
	// ------------------------------------------------------------

	// Free millisecond tick for the touch timers
	tick_divider #(.PERIOD(MS_CYC)) u_ms_tick (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_restart  (1'h0),
		.o_tick     (tif.tick_ms)
	);

	// Millisecond tick aligned to cycle start
	tick_divider #(.PERIOD(MS_CYC)) u_cyc_tick (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_restart  (cyc_start),
		.o_tick     (cyc_tick)
	);

	// Sample-time unit tick aligned to cycle start
	tick_divider #(.PERIOD(SAMP_CYC)) u_smp_tick (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_restart  (cyc_start),
		.o_tick     (smp_tick)
	);

	// ------------------------------------------------------------
	// Sensing cycle sequencer
	// ------------------------------------------------------------

	// Decoded shadow settings
	assign avg_code   = sh_avg_r[AVG_MSB:AVG_LSB];
	assign smp_units  = SMP_ONE << sh_avg_r[SMP_MSB:SMP_LSB];
	assign avg_cnt    = AVG_ONE << avg_code;
	assign cyc_done   = cyc_ms_r >=
		step_ms({2'h0, sh_avg_r[CYC_MSB:CYC_LSB]});
	assign cyc_start  = i_active_mode &&
		(st_r == ST_IDLE || (st_r == ST_WAIT && cyc_done));
	assign smp_last   = units_r == smp_units - SMP_ONE;
	assign meas_last  = idx_r == avg_cnt - AVG_ONE;
	assign acc_sum    = acc_r + ACC_W'(i_sample_data);
	assign first_pick = pick_ch(i_chan_enable, 2'h0);
	assign next_pick  = pick_ch(sh_en_r, ch_r + 2'h1);

	// Next state of the sequencer
	always_comb begin
		st_nxt      = st_r;
		ch_nxt      = ch_r;
		units_nxt   = units_r;
		idx_nxt     = idx_r;
		acc_nxt     = acc_r;
		sh_dur_nxt  = sh_dur_r;
		sh_hold_nxt = sh_hold_r;
		sh_avg_nxt  = sh_avg_r;
		sh_en_nxt   = sh_en_r;
		strobe_nxt  = 1'h0;
		mval_nxt    = 1'h0;
		mchan_nxt   = o_meas_chan;
		mres_nxt    = o_meas_result;
		cyc_ms_nxt  = cyc_ms_r;
		if (cyc_tick && cyc_ms_r != '1) begin
			cyc_ms_nxt = cyc_ms_r + 14'h0001;
		end
		case (st_r)
			ST_IDLE, ST_WAIT: begin
				if (cyc_start) begin
					sh_dur_nxt  = reg_dur_r;
					sh_hold_nxt = reg_hold_r;
					sh_avg_nxt  = reg_avg_r;
					sh_en_nxt   = i_chan_enable;
					cyc_ms_nxt  = '0;
					units_nxt   = '0;
					idx_nxt     = '0;
					acc_nxt     = '0;
					if (first_pick[2]) begin
						st_nxt = ST_SAMPLE;
						ch_nxt = first_pick[1:0];
					end else begin
						st_nxt = ST_WAIT;
					end
				end else if (st_r == ST_WAIT && !i_active_mode) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_SAMPLE: begin
				if (smp_tick) begin
					if (smp_last) begin
						units_nxt  = '0;
						strobe_nxt = 1'h1;
						if (meas_last) begin
							mval_nxt  = 1'h1;
							mchan_nxt = ch_r;
							mres_nxt  = DATA_W'(acc_sum >> avg_code);
							acc_nxt   = '0;
							idx_nxt   = '0;
							if (next_pick[2]) begin
								ch_nxt = next_pick[1:0];
							end else begin
								st_nxt = ST_WAIT;
							end
						end else begin
							acc_nxt = acc_sum;
							idx_nxt = idx_r + 8'h01;
						end
					end else begin
						units_nxt = units_r + 4'h1;
					end
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
		busy_nxt = st_nxt == ST_SAMPLE;
		lp_nxt   = st_nxt != ST_SAMPLE;
	end

	// Sequencer registers
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r            <= ST_IDLE;
			ch_r            <= 2'h0;
			units_r         <= 4'h0;
			idx_r           <= 8'h00;
			acc_r           <= '0;
			cyc_ms_r        <= '0;
			sh_dur_r        <= RST_DUR_RPT;
			sh_hold_r       <= RST_HOLD;
			sh_avg_r        <= RST_AVG;
			sh_en_r         <= '0;
			o_sample_strobe <= 1'h0;
			o_sample_busy   <= 1'h0;
			o_low_power     <= 1'h1;
			o_meas_valid    <= 1'h0;
			o_meas_chan     <= 2'h0;
			o_meas_result   <= '0;
		end else begin
			st_r            <= st_nxt;
			ch_r            <= ch_nxt;
			units_r         <= units_nxt;
			idx_r           <= idx_nxt;
			acc_r           <= acc_nxt;
			cyc_ms_r        <= cyc_ms_nxt;
			sh_dur_r        <= sh_dur_nxt;
			sh_hold_r       <= sh_hold_nxt;
			sh_avg_r        <= sh_avg_nxt;
			sh_en_r         <= sh_en_nxt;
			o_sample_strobe <= strobe_nxt;
			o_sample_busy   <= busy_nxt;
			o_low_power     <= lp_nxt;
			o_meas_valid    <= mval_nxt;
			o_meas_chan     <= mchan_nxt;
			o_meas_result   <= mres_nxt;
		end
	end

	assign o_sample_chan = ch_r;

	// ------------------------------------------------------------
	// Touch timers
	// ------------------------------------------------------------

	assign tif.touch    = i_touch;
	assign tif.recal_en = i_recal_enable;
	assign tif.rpt_en   = i_repeat_enable;
	assign tif.dur      = dur_ms(sh_dur_r[DUR_MSB:DUR_LSB]);
	assign tif.hold     = step_ms(sh_hold_r[HLD_MSB:HLD_LSB]);
	assign tif.rpt      = step_ms(sh_dur_r[RPT_MSB:RPT_LSB]);

	// One timer per input
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		touch_hold_timer #(.CH(g)) u_timer (
			.i_core_clk (i_core_clk),
			.i_rstn     (i_rstn),
			.tif        (tif.chan)
		);
		assign o_int_req[g]    = tif.int_req[g];
		assign o_recal_req[g]  = tif.recal_req[g];
		assign o_hold_event[g] = tif.hold_evt[g];
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	property p_reg_write;
		i_reg_wr && i_reg_addr == ADDR_HOLD
			|=> reg_hold_r == ($past(i_reg_wdata) & MASK_HOLD);
	endproperty
	a_reg_write: assert property (p_reg_write)
		else $error("hold register write lost");

	property p_shadow_load;
		$changed(sh_avg_r) |-> $past(cyc_start);
	endproperty
	a_shadow_load: assert property (p_shadow_load)
		else $error("settings changed inside a cycle");

	property p_enabled_only;
		o_sample_busy |-> sh_en_r[o_sample_chan];
	endproperty
	a_enabled_only: assert property (p_enabled_only)
		else $error("disabled channel sampled");

	property p_meas_chan;
		o_meas_valid |-> $past(ch_r) == o_meas_chan && $past(meas_last);
	endproperty
	a_meas_chan: assert property (p_meas_chan)
		else $error("result without full sample set");

	property p_no_cut;
		st_r == ST_SAMPLE |=> st_r != ST_IDLE && $stable(sh_avg_r);
	endproperty
	a_no_cut: assert property (p_no_cut)
		else $error("cycle cut short while sampling");

	property p_wait_lp;
		st_r == ST_WAIT ##1 st_r == ST_WAIT |-> o_low_power && !o_sample_busy;
	endproperty
	a_wait_lp: assert property (p_wait_lp)
		else $error("not in low power during wait");

	c_meas:    cover property (o_meas_valid);
	c_stretch: cover property (st_r == ST_SAMPLE && cyc_done);
	c_repeat:  cover property (o_hold_event[0] && o_int_req[0]);
	c_recal:   cover property (o_recal_req != '0);

endmodule // touch_sense_timing_config

// [tb.sv]
// Self-checking bench for the touch timing configuration block
module tb
	import touch_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	localparam int MSC = 10;   // Cycles per ms, scaled down
	localparam int SC  = 4;    // Cycles per 320 us unit
	logic       i_core_clk;
	logic       i_rstn;
	logic [7:0] i_reg_addr;
	logic       i_reg_wr;
	logic [7:0] i_reg_wdata;
	logic [7:0] o_reg_rdata;
	logic       i_active_mode;
	logic       i_recal_enable;
	logic [2:0] i_chan_enable;
	logic [2:0] i_repeat_enable;
	logic [2:0] i_touch;
	logic [7:0] i_sample_data = 8'h00;
	logic       o_sample_busy;
	logic [1:0] o_sample_chan;
	logic       o_sample_strobe;
	logic       o_low_power;
	logic       o_meas_valid;
	logic [1:0] o_meas_chan;
	logic [7:0] o_meas_result;
	logic [2:0] o_int_req;
	logic [2:0] o_recal_req;
	logic [2:0] o_hold_event;
	int         num_errors = 0;
	int         samples_checked = 0;
	int         seed = 6711;
	logic [7:0] mdl [3] = '{8'hA4, 8'h07, 8'h39};
	logic [7:0] msk [3] = '{8'hFF, 8'h0F, 8'h7F};
	int         cnt_int [3] = '{0, 0, 0};
	int         cnt_rec [3] = '{0, 0, 0};
	int         period = 0;
	int         starts = 0;
	int         q_ch [$];
	int         acc = 0;
	int         nsmp = 0;
	int         cyc_n = 0;
	int         last_start = 0;
	int         sh_avg = 3;
	logic       lp_q = 1'b1;
	int         c_avg [6] = '{1, 0, 2, 3, 5, 7};
	int         c_smp [6] = '{0, 3, 2, 1, 0, 0};
	int         c_cyc [6] = '{0, 1, 2, 3, 0, 0};
	int         c_en [6] = '{5, 2, 7, 6, 7, 1};

	touch_sense_timing_config #(.MS_CYC(MSC), .SAMP_CYC(SC))
		u_touch_sense_timing_config (
		.i_core_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
		.o_reg_rdata, .i_active_mode, .i_recal_enable, .i_chan_enable,
		.i_repeat_enable, .i_touch, .i_sample_data, .o_sample_busy,
		.o_sample_chan, .o_sample_strobe, .o_low_power, .o_meas_valid,
		.o_meas_chan, .o_meas_result, .o_int_req, .o_recal_req,
		.o_hold_event
	);

	// Core clock, 8 ns period
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Register write, model follows with field masks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_core_clk);
		i_reg_addr = a;
		i_reg_wr = 1'b1;
		i_reg_wdata = d;
		@(negedge i_core_clk);
		i_reg_wr = 1'b0;
		if (a >= 8'h22 && a <= 8'h24)
			mdl[a - 8'h22] = d & msk[a - 8'h22];
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		i_reg_addr = a;
		@(negedge i_core_clk);
		d = o_reg_rdata;
	endtask

	// Bounded wait for a number of cycle starts
	task automatic wait_starts(input int n);
		int s0;
		s0 = starts;
		for (int i = 0; i < 40000 && starts < s0 + n; i++)
			@(negedge i_core_clk);
		if (starts < s0 + n) begin
			num_errors++;
			final_report();
		end
	endtask

	// Cycle, sample and pulse monitor with averaging model
	always @(negedge i_core_clk) begin
		cyc_n++;
		for (int c = 0; c < 3; c++) begin
			if (o_int_req[c] === 1'b1)
				cnt_int[c] <= cnt_int[c] + 1;
			if (o_recal_req[c] === 1'b1)
				cnt_rec[c] <= cnt_rec[c] + 1;
		end
		if (o_sample_strobe === 1'b1) begin
			acc += int'(i_sample_data);
			nsmp++;
			i_sample_data <= 8'($random(seed));
		end
		if (o_meas_valid === 1'b1) begin
			chk(nsmp, 1 << sh_avg);
			chk(o_meas_result, acc >> sh_avg);
			chk(o_meas_chan, q_ch.size() > 0 ? q_ch.pop_front() : 9);
			acc = 0;
			nsmp = 0;
		end
		if (o_low_power === 1'b0 && lp_q === 1'b1) begin
			chk(q_ch.size(), 0);
			period <= cyc_n - last_start;
			last_start = cyc_n;
			starts <= starts + 1;
			sh_avg = mdl[2][6:4];
			for (int c = 0; c < 3; c++)
				if (i_chan_enable[c]) q_ch.push_back(c);
		end
		// Channel in sampling is the head of the expected order
		if (o_sample_busy === 1'b1)
			chk(o_sample_chan, q_ch.size() > 0 ? q_ch[0] : 9);
		lp_q = o_low_power;
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		logic [7:0] v;
		int a;
		int b0;
		int b1;
		int smp;
		int cyc;
		int ext;
		i_rstn = 1'b0;
		i_reg_addr = 8'h00;
		i_reg_wr = 1'b0;
		i_reg_wdata = 8'h00;
		i_active_mode = 1'b0;
		i_recal_enable = 1'b0;
		i_chan_enable = 3'b111;
		i_repeat_enable = 3'b000;
		i_touch = 3'b000;
		repeat (6) @(negedge i_core_clk);
		i_rstn = 1'b1;
		repeat (20) @(negedge i_core_clk);
		chk(o_low_power, 1'b1);
		chk(o_sample_busy, 1'b0);
		// Reset values, unmapped reads, random writes
		for (int k = 0; k < 24; k++) begin
			a = (k < 5) ? 8'h21 + k : 8'h21 + ($random(seed) & 3);
			if (k >= 5)
				wr(8'(a), 8'($random(seed)));
			rd(8'(a), v);
			chk(v, (a >= 8'h22 && a <= 8'h24) ? mdl[a - 8'h22] : 0);
		end
		i_active_mode = 1'b1;
		// Cycle length, stretch and low-power wait per setting
		for (int k = 0; k < 6; k++) begin
			wr(8'h24, 8'((c_avg[k] << 4) | (c_smp[k] << 2) | c_cyc[k]));
			i_chan_enable = 3'(c_en[k]);
			wait_starts(3);
			smp = (1 << (c_avg[k] + c_smp[k])) * SC * $countones(3'(c_en[k]));
			cyc = (c_cyc[k] + 1) * 35 * MSC;
			ext = smp > cyc;
			chk(ext ? (period >= smp && period <= smp + 16) :
				(period >= cyc && period <= cyc + 2), 1);
			// Just past sampling: waiting unless the cycle was stretched
			repeat (smp + 8) @(negedge i_core_clk);
			chk(o_low_power, !ext);
		end
		// Mid-cycle write waits for the next cycle
		wr(8'h24, 8'h00);
		i_chan_enable = 3'b001;
		wait_starts(2);
		wr(8'h24, 8'h03);
		wait_starts(1);
		chk(period >= 35 * MSC && period <= 35 * MSC + 2, 1);
		wait_starts(1);
		chk(period >= 140 * MSC && period <= 140 * MSC + 2, 1);
		// Touch timers: shortest hold, repeat and timeout
		wr(8'h22, 8'h00);
		wr(8'h23, 8'h00);
		wr(8'h24, 8'h00);
		wait_starts(2);
		i_recal_enable = 1'b1;
		i_repeat_enable = 3'b001;
		b0 = cnt_int[0];
		b1 = cnt_int[1];
		i_touch = 3'b011;
		repeat (4) @(negedge i_core_clk);
		chk(cnt_int[0] - b0, 1);
		chk(cnt_int[1] - b1, 1);
		repeat (34 * MSC - 4) @(negedge i_core_clk);
		chk(o_hold_event, 3'b000);
		repeat (4 * MSC) @(negedge i_core_clk);
		chk(o_hold_event, 3'b001);
		repeat (152 * MSC) @(negedge i_core_clk);
		chk(cnt_int[0] - b0, 5);
		chk(cnt_int[1] - b1, 1);
		repeat (365 * MSC) @(negedge i_core_clk);
		chk(cnt_rec[0] + cnt_rec[1], 0);
		repeat (15 * MSC) @(negedge i_core_clk);
		chk(cnt_rec[0], 1);
		chk(cnt_rec[1], 1);
		chk(cnt_rec[2], 0);
		repeat (130 * MSC) @(negedge i_core_clk);
		chk(cnt_rec[0], 1);
		i_touch = 3'b000;
		repeat (5) @(negedge i_core_clk);
		chk(o_hold_event, 3'b000);
		i_recal_enable = 1'b0;
		i_touch = 3'b100;
		repeat (600 * MSC) @(negedge i_core_clk);
		chk(cnt_rec[2], 0);
		chk(o_hold_event, 3'b000);
		// Longer codes: 840 ms timeout, 105 ms repeat, 70 ms hold
		i_touch = 3'b000;
		wr(8'h22, 8'h12);
		wr(8'h23, 8'h01);
		wait_starts(2);
		i_recal_enable = 1'b1;
		i_repeat_enable = 3'b100;
		b0 = cnt_int[2];
		i_touch = 3'b100;
		repeat (69 * MSC) @(negedge i_core_clk);
		chk(o_hold_event, 3'b000);
		repeat (4 * MSC) @(negedge i_core_clk);
		chk(o_hold_event, 3'b100);
		// Touch interrupt plus seven 105 ms repeats by 835 ms
		repeat (762 * MSC) @(negedge i_core_clk);
		chk(cnt_int[2] - b0, 8);
		chk(cnt_rec[2], 0);
		repeat (10 * MSC) @(negedge i_core_clk);
		chk(cnt_rec[2], 1);
		final_report();
	end
endmodule // tb
